// File: hdl/loader_pkg.sv
package loader_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int BAUD = 9600;
	localparam int BIT_CYCLES = CLK_HZ / BAUD;
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 1;
	localparam int ERASE_MS_PER_SEG = 16 * 2;
	localparam int ERASE_CYCLES = ERASE_MS_PER_SEG * (CLK_HZ / 1000);
	localparam int PARITY_BITS = 0;
	localparam logic [7:0] SYNC_CHAR = 8'h80;
	localparam logic [7:0] ACK_CHAR = 8'h90;
	localparam logic [7:0] NACK_CHAR = 8'ha0;
	localparam logic [7:0] CHECKSUM_RESET = 8'h00;
	localparam int FIFO_DEPTH = 4;
endpackage

// File: hdl/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = count_q != (AW+1)'(DEPTH);
	assign out_valid = count_q != '0;
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= step(wr_q);
			end
			if (pop) begin
				rd_q <= step(rd_q);
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/uart_firmware_update_loader.sv
// What this block does
// - Serial link is 9600 baud, eight data bits, one stop bit, no parity.
// - Entry pin high at reset release selects update mode, else application.
// - After sync, erase main flash, restore vectors; host waits segments*16*2 ms.
// - Code bytes, flash size minus two, are programmed in order.
// - Last byte is the XOR checksum, not part of the code bytes.
// - Running XOR of code bytes kept in a dedicated checksum register.
// - After the checksum byte exactly one response byte is sent.
// - After a positive acknowledge the device forces its own reset.
// - Serial timing is derived from the calibrated clock.
// - User code is never written into information memory.
// - After success execution starts at the fixed application start.
`timescale 1ns/1ps
`default_nettype none
module uart_firmware_update_loader #(
	parameter int CODE_BYTES = 510,
	parameter int ADDR_W = 16,
	parameter logic [15:0] MAIN_BASE = 16'hfe00,
	parameter int NUM_SEGMENTS = 1,
	parameter int ERASE_CYCLES = NUM_SEGMENTS * loader_pkg::ERASE_CYCLES,
	parameter int BIT_CYCLES = loader_pkg::BIT_CYCLES,
	parameter logic [7:0] SYNC_CHAR = loader_pkg::SYNC_CHAR,
	parameter logic [7:0] ACK_CHAR = loader_pkg::ACK_CHAR,
	parameter logic [7:0] NACK_CHAR = loader_pkg::NACK_CHAR
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic entry_pin,
	input wire logic rxd,
	output logic txd,
	output logic update_mode,
	output logic app_start,
	output logic self_reset,
	output logic erase_req,
	output logic vectors_restore,
	input wire logic flash_busy,
	output logic prog_we,
	output logic [ADDR_W-1:0] prog_addr,
	output logic [7:0] prog_data,
	output logic [7:0] running_checksum_reg
);
	typedef enum {
		ST_START, ST_APP, ST_SYNC, ST_ERASE, ST_CODE, ST_CHECK, ST_RESP,
		ST_DONE
	} state_type;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_type;

	localparam int HALF = BIT_CYCLES / 2;
	localparam int CW = $clog2(BIT_CYCLES + 1);

	state_type state_q;
	rx_type rx_q;
	logic [CW-1:0] rx_cnt_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic code_take;
	logic sync_seen;
	logic erase_last;
	logic [7:0] f_data;
	logic f_valid;
	logic f_ready;
	logic [31:0] erase_q;
	logic [15:0] idx_q;
	logic [7:0] rx_byte_q;
	logic rx_valid_q;
	logic ok_q;
	logic tx_go;
	logic tx_busy_q;
	logic [9:0] tx_sh_q;
	logic [CW-1:0] tx_cnt_q;
	logic [3:0] tx_bit_q;

	// ==========================================
	// Receiver
	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_q <= RX_IDLE;
			rx_cnt_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
			rx_valid_q <= 1'b0;
			rx_byte_q <= '0;
		end else begin
			rx_valid_q <= 1'b0;
			case (rx_q)
			RX_IDLE: begin
				if (!rxd) begin
					rx_q <= RX_START;
					rx_cnt_q <= '0;
				end
			end
			RX_START: begin
				if (rx_cnt_q == CW'(HALF)) begin
					rx_cnt_q <= '0;
					rx_bit_q <= '0;
					rx_q <= rxd ? RX_IDLE : RX_DATA;
				end else begin
					rx_cnt_q <= rx_cnt_q + 1'b1;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == CW'(BIT_CYCLES - 1)) begin
					rx_cnt_q <= '0;
					rx_sh_q <= {rxd, rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 1'b1;
					if (rx_bit_q == 4'(loader_pkg::DATA_BITS - 1)) begin
						rx_q <= RX_STOP;
					end
				end else begin
					rx_cnt_q <= rx_cnt_q + 1'b1;
				end
			end
			RX_STOP: begin
				if (rx_cnt_q == CW'(BIT_CYCLES - 1)) begin
					rx_q <= RX_IDLE;
					rx_valid_q <= rxd;
					rx_byte_q <= rx_sh_q;
				end else begin
					rx_cnt_q <= rx_cnt_q + 1'b1;
				end
			end
			default: rx_q <= RX_IDLE;
			endcase
		end
	end
	assign rx_valid = rx_valid_q;
	assign rx_byte = rx_byte_q;

	// ==========================================
	// Byte buffer
	byte_fifo #(.WIDTH(8), .DEPTH(loader_pkg::FIFO_DEPTH)) fifo_i (
		.mclk(mclk),
		.reset(reset),
		.in_data(rx_byte),
		.in_valid(rx_valid),
		.in_ready(),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);
	assign f_ready = (state_q == ST_SYNC) || (state_q == ST_CHECK)
		|| (state_q == ST_CODE && !flash_busy && !prog_we);

	// ==========================================
	// Shared decodes
	function automatic logic sum_match(input logic [7:0] got,
		input logic [7:0] acc);
		sum_match = got == acc;
	endfunction
	assign code_take = state_q == ST_CODE && f_valid && f_ready;
	assign sync_seen = f_valid && f_data == SYNC_CHAR;
	assign erase_last = erase_q == 32'(ERASE_CYCLES - 1);

	// ==========================================
	// Sequencer
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= ST_START;
			erase_q <= '0;
			idx_q <= '0;
			ok_q <= 1'b0;
		end else begin
			case (state_q)
			ST_START: begin
				state_q <= entry_pin ? ST_SYNC : ST_APP;
			end
			ST_APP: begin
				state_q <= ST_APP;
			end
			ST_SYNC: begin
				if (sync_seen) begin
					state_q <= ST_ERASE;
					erase_q <= '0;
				end
			end
			ST_ERASE: begin
				if (erase_last) begin
					state_q <= ST_CODE;
					idx_q <= '0;
				end else begin
					erase_q <= erase_q + 1'b1;
				end
			end
			ST_CODE: begin
				if (code_take) begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == 16'(CODE_BYTES - 1)) begin
						state_q <= ST_CHECK;
					end
				end
			end
			ST_CHECK: begin
				if (f_valid) begin
					ok_q <= sum_match(f_data, running_checksum_reg);
					state_q <= ST_RESP;
				end
			end
			ST_RESP: begin
				if (!tx_busy_q && !tx_go) begin
					state_q <= ok_q ? ST_DONE : ST_SYNC;
				end
			end
			ST_DONE: state_q <= ST_DONE;
			default: state_q <= ST_START;
			endcase
		end
	end

	// ==========================================
	// Checksum and flash programming
	always_ff @(posedge mclk) begin
		if (reset) begin
			running_checksum_reg <= loader_pkg::CHECKSUM_RESET;
		end else if (state_q == ST_ERASE) begin
			running_checksum_reg <= loader_pkg::CHECKSUM_RESET;
		end else if (code_take) begin
			running_checksum_reg <= running_checksum_reg ^ f_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			prog_we <= 1'b0;
			prog_addr <= '0;
			prog_data <= '0;
		end else begin
			prog_we <= code_take;
			if (code_take) begin
				prog_addr <= ADDR_W'(MAIN_BASE + idx_q);
				prog_data <= f_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			erase_req <= 1'b0;
			vectors_restore <= 1'b0;
		end else begin
			erase_req <= state_q == ST_SYNC && sync_seen;
			vectors_restore <= state_q == ST_ERASE && erase_last;
		end
	end

	// ==========================================
	// Transmitter
	assign tx_go = state_q == ST_CHECK && f_valid;
	always_ff @(posedge mclk) begin
		if (reset) begin
			tx_busy_q <= 1'b0;
			tx_sh_q <= '1;
			tx_cnt_q <= '0;
			tx_bit_q <= '0;
		end else if (tx_go) begin
			tx_busy_q <= 1'b1;
			tx_sh_q <= {1'b1, sum_match(f_data, running_checksum_reg)
				? ACK_CHAR : NACK_CHAR, 1'b0};
			tx_cnt_q <= '0;
			tx_bit_q <= '0;
		end else if (tx_busy_q) begin
			if (tx_cnt_q == CW'(BIT_CYCLES - 1)) begin
				tx_cnt_q <= '0;
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_bit_q <= tx_bit_q + 1'b1;
				if (tx_bit_q == 4'(loader_pkg::DATA_BITS + 1)) begin
					tx_busy_q <= 1'b0;
				end
			end else begin
				tx_cnt_q <= tx_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================
	// Outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			txd <= 1'b1;
		end else begin
			txd <= tx_sh_q[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			update_mode <= 1'b0;
			app_start <= 1'b0;
			self_reset <= 1'b0;
		end else begin
			update_mode <= state_q != ST_START && state_q != ST_APP
				&& state_q != ST_DONE;
			app_start <= state_q == ST_APP;
			self_reset <= state_q == ST_DONE;
		end
	end
endmodule
`default_nettype wire

// File: verif/loader_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module loader_asserts #(
	parameter int ADDR_W = 16,
	parameter int CODE_BYTES = 510,
	parameter logic [15:0] MAIN_BASE = 16'hfe00,
	parameter int ERASE_CYCLES = 320000
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic txd,
	input wire logic update_mode,
	input wire logic app_start,
	input wire logic self_reset,
	input wire logic erase_req,
	input wire logic vectors_restore,
	input wire logic prog_we,
	input wire logic [ADDR_W-1:0] prog_addr
);
	int wait_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// ====================
	// Erase wait counter
	always_ff @(posedge mclk) begin
		if (reset || erase_req) begin
			wait_q <= 0;
		end else if (wait_q < ERASE_CYCLES) begin
			wait_q <= wait_q + 1;
		end
	end
	sequence s_low8;
		!txd [*8];
	endsequence
	sequence s_idle2;
		txd ##1 txd;
	endsequence
	// ====================
	// Properties
	a_erase_pulse: assert property (erase_req |=> !erase_req)
		else $error("erase pulse too long");
	a_erase_mode: assert property (erase_req |-> update_mode)
		else $error("erase outside update");
	a_erase_wait: assert property (
		vectors_restore |-> wait_q >= ERASE_CYCLES - 2)
		else $error("vectors before erase time");
	a_we_pulse: assert property (prog_we |=> !prog_we)
		else $error("write pulse too long");
	a_we_mode: assert property (prog_we |-> update_mode)
		else $error("write outside update");
	a_addr_main: assert property (prog_we |-> prog_addr >= MAIN_BASE &&
		prog_addr < MAIN_BASE + CODE_BYTES) else $error("address off main");
	a_mode_excl: assert property (!(update_mode && app_start))
		else $error("both modes");
	a_start_width: assert property ($fell(txd) |-> s_low8)
		else $error("short start bit");
	a_self_idle: assert property ($rose(self_reset) |-> s_idle2)
		else $error("line busy at self reset");
endmodule
`default_nettype wire

// File: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic mclk,
	output logic rxd,
	input wire logic txd
);
	initial rxd = 1'b1;
	// ====================
	// Frames: start, eight bits lsb first, one stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (BIT_CYCLES) @(negedge mclk);
		end
	endtask
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (txd !== 1'b0 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		repeat (BIT_CYCLES / 2) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(negedge mclk);
			b[i] = txd;
		end
		repeat (BIT_CYCLES) @(negedge mclk);
		ok = n < 4000 && txd === 1'b1;
	endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] BASE = 16'hfe00;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic entry_pin = 1'b0;
	logic flash_busy = 1'b0;
	logic rxd, txd, update_mode, app_start, self_reset, erase_req;
	logic vectors_restore, prog_we;
	logic [15:0] prog_addr;
	logic [7:0] prog_data, running_checksum_reg;
	logic [15:0] wa[$];
	logic [7:0] wd[$];
	int failures = 0;
	int checked = 0;
	int ne, nv;
	time te, tv;
	always #50 mclk = ~mclk;
	// ====================
	// Output monitor
	always @(negedge mclk) begin
		if (prog_we === 1'b1) begin
			wa.push_back(prog_addr);
			wd.push_back(prog_data);
		end
		if (erase_req === 1'b1) begin
			ne++;
			te = $time;
		end
		if (vectors_restore === 1'b1) begin
			nv++;
			tv = $time;
		end
	end
	uart_firmware_update_loader #(.CODE_BYTES(4), .MAIN_BASE(BASE),
		.ERASE_CYCLES(50), .BIT_CYCLES(16)) dut_u (.mclk(mclk),
		.reset(reset), .entry_pin(entry_pin), .rxd(rxd), .txd(txd),
		.update_mode(update_mode), .app_start(app_start),
		.self_reset(self_reset), .erase_req(erase_req),
		.vectors_restore(vectors_restore), .flash_busy(flash_busy),
		.prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
		.running_checksum_reg(running_checksum_reg));
	host_model #(.BIT_CYCLES(16)) host_u (.mclk(mclk), .rxd(rxd), .txd(txd));
	// ====================
	// Helpers
	task chk(input logic c, input string m);
		checked++;
		if (c !== 1'b1) begin
			failures++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task end_of_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic restart(input logic ent);
		reset = 1'b1;
		entry_pin = ent;
		repeat (6) @(negedge mclk);
		reset = 1'b0;
		repeat (3) @(negedge mclk);
		entry_pin = 1'b0;
	endtask
	task automatic xfer(input logic [31:0] d, input logic [7:0] c,
		input logic busy, output logic [7:0] r);
		logic ok;
		int n;
		logic [7:0] sum;
		wa.delete();
		wd.delete();
		ne = 0;
		nv = 0;
		host_u.send(loader_pkg::SYNC_CHAR);
		n = 0;
		while (nv == 0 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		chk(ne == 1 && nv == 1 && tv - te >= 5000, "erase");
		if (nv == 0) begin
			end_of_test();
		end
		flash_busy = busy;
		for (int i = 0; i < 4; i++) begin
			host_u.send(d[8*i +: 8]);
		end
		chk(wa.size() == (busy ? 0 : 4), "stall");
		flash_busy = 1'b0;
		repeat (20) @(negedge mclk);
		chk(wa.size() == 4, "count");
		for (int i = 0; i < 4; i++) begin
			chk(wa[i] === BASE + 16'(i), "address");
			chk(wd[i] === d[8*i +: 8], "data");
		end
		sum = d[7:0] ^ d[15:8] ^ d[23:16] ^ d[31:24];
		chk(running_checksum_reg === sum, "sum");
		fork
			host_u.send(c);
			host_u.recv(r, ok);
		join
		n = 0;
		repeat (400) begin
			@(negedge mclk);
			if (txd !== 1'b1) n++;
		end
		chk(ok === 1'b1 && n == 0 && wa.size() == 4, "reply");
		if (ok !== 1'b1) begin
			end_of_test();
		end
	endtask
	// ====================
	// Scenarios
	task automatic s_app;
		restart(1'b0);
		chk(app_start === 1'b1 && update_mode === 1'b0, "app");
		ne = 0;
		host_u.send(loader_pkg::SYNC_CHAR);
		repeat (20) @(negedge mclk);
		chk(ne == 0 && txd === 1'b1, "app quiet");
	endtask
	task automatic s_ack;
		logic [7:0] r;
		restart(1'b1);
		chk(update_mode === 1'b1 && app_start === 1'b0, "entry");
		ne = 0;
		host_u.send(8'h55);
		repeat (20) @(negedge mclk);
		chk(ne == 0, "junk taken");
		xfer(32'h12345678, 8'h08, 1'b1, r);
		chk(r === loader_pkg::ACK_CHAR, "ack");
		chk(self_reset === 1'b1, "ack reset");
	endtask
	task automatic s_retry;
		logic [7:0] r;
		restart(1'b1);
		xfer(32'ha5c30ff0, 8'h98, 1'b0, r);
		chk(r === loader_pkg::NACK_CHAR, "nack");
		chk(self_reset === 1'b0 && update_mode === 1'b1, "stay");
		xfer(32'ha5c30ff0, 8'h99, 1'b0, r);
		chk(r === loader_pkg::ACK_CHAR, "retry");
		chk(self_reset === 1'b1, "retry reset");
	endtask
	initial begin
		s_app();
		s_ack();
		s_retry();
		end_of_test();
	end
endmodule
bind uart_firmware_update_loader loader_asserts #(.ADDR_W(ADDR_W),
	.CODE_BYTES(CODE_BYTES), .MAIN_BASE(MAIN_BASE),
	.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.mclk(mclk), .reset(reset),
	.txd(txd), .update_mode(update_mode), .app_start(app_start),
	.self_reset(self_reset), .erase_req(erase_req),
	.vectors_restore(vectors_restore), .prog_we(prog_we),
	.prog_addr(prog_addr));
`default_nettype wire
